// *** inc/tofgc_map.svh ***
// register offsets, field positions, reset values and widths of the control bank
`ifndef TOFGC_MAP_SVH
`define TOFGC_MAP_SVH

// ****************************************
// bus widths
// ****************************************
`define TOFGC_DW 24
`define TOFGC_AW 8

// ****************************************
// register offsets
// ****************************************
`define TOFGC_OFS_RESET 8'h00
`define TOFGC_OFS_UPDATE 8'h02
`define TOFGC_OFS_LATENCY 8'h04
`define TOFGC_OFS_AMBIENT 8'h05
`define TOFGC_OFS_POWER 8'h08
`define TOFGC_OFS_SETUP 8'h0B

// ****************************************
// field positions
// ****************************************
`define TOFGC_BIT_CLEAR 0
`define TOFGC_BIT_APPLY 2
`define TOFGC_BIT_EARLY 22
`define TOFGC_BIT_AMBIENT 21
`define TOFGC_BIT_STANDBY 2
`define TOFGC_BIT_SETUP 13

// ****************************************
// reset values
// ****************************************
`define TOFGC_RST_ZERO 1'h0
`define TOFGC_RST_STANDBY 1'h1
`define TOFGC_RST_WORD 24'h000000

`endif

// *** inc/tofgc_pkg.sv ***
// types shared by the time-of-flight global control bank
package tofgc_pkg;

   // one register word
   typedef logic [23:0] tofgc_data_t;

   // register address
   typedef logic [7:0] tofgc_addr_t;

   // depth processing launch states
   typedef enum logic [0:0] {
      TOFGC_IDLE = 1'b0,
      TOFGC_WAIT = 1'b1
   } tofgc_state_t;

endpackage

// *** hdl/tofgc_regs.sv ***
// global control register bank of a time-of-flight depth sensor
//
// How it works
// R01: writing one to clear bit restores everything
// R02: new synth setting taken only on apply pulse
// R03: early select starts processing after last quad
// R04: high ambient holds pixel reset during readout
// R05: software uses high ambient only with shutter
// R06: standby bit one keeps device in standby
// R07: standby resets to one; software clears it
// R08: software sets setup bit; it resets to zero
// R09: reserved read-write bits store nothing, read zero
// R10: write-only reserved bits read back zero
`timescale 1ns/1ns
`include "tofgc_map.svh"

module tofgc_regs (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [23:0] reg_rdata,
   input wire logic [23:0] synth_setting,
   output logic [23:0] synth_active,
   output logic synth_load,
   input wire logic quad_readout_done,
   input wire logic frame_boundary,
   input wire logic readout_active,
   output logic depth_start,
   output logic pixel_reset_hold,
   output logic standby,
   output logic setup_done,
   output logic sensor_soft_clear
);

   // ****************************************
   // declarations
   // ****************************************

   // stored control bits, one per documented field, plus the apply history bit
   logic clear_q; // sensor_soft_clear field
   logic apply_q; // modulation_synth_apply field
   logic apply_prev_q; // apply bit one cycle ago
   logic early_q; // early_process_select field
   logic ambient_q; // high ambient pixel reset mode
   logic standby_q; // standby field
   logic setup_q; // mandatory setup field

   // synthesizer word actually in use
   logic [23:0] synth_active_q;
   logic synth_load_q;

   // processing launch
   tofgc_pkg::tofgc_state_t state_q;
   logic start_q;

   // read path
   logic [23:0] rd_word;
   logic [23:0] rdata_q;

   // write strobes per register
   logic wr_reset;
   logic wr_update;
   logic wr_latency;
   logic wr_ambient;
   logic wr_power;
   logic wr_setup;

   // restore request: hard reset or the soft clear bit
   logic restore;

   // falling edge of the apply bit
   logic apply_fall;

   // ****************************************
   // address decode
   // ****************************************

   // one strobe per register, only on an exact offset
   assign wr_reset = reg_wr && (reg_addr == `TOFGC_OFS_RESET);
   assign wr_update = reg_wr && (reg_addr == `TOFGC_OFS_UPDATE);
   assign wr_latency = reg_wr && (reg_addr == `TOFGC_OFS_LATENCY);
   assign wr_ambient = reg_wr && (reg_addr == `TOFGC_OFS_AMBIENT);
   assign wr_power = reg_wr && (reg_addr == `TOFGC_OFS_POWER);
   assign wr_setup = reg_wr && (reg_addr == `TOFGC_OFS_SETUP);

   // the stored clear bit acts in the cycle after its write
   assign restore = srst || clear_q; // R01

   // ****************************************
   // soft clear
   // ****************************************

   // self clearing: the restore it causes also wipes the bit itself,
   // so software never has to write it back to zero
   always_ff @(posedge clk) begin
      if (restore) begin
         clear_q <= `TOFGC_RST_ZERO; // R01
      end else if (wr_reset) begin
         // only bit 0 is stored, the rest is reserved
         clear_q <= reg_wdata[`TOFGC_BIT_CLEAR]; // R01 R09
      end
   end

   // ****************************************
   // synthesizer apply bit
   // ****************************************

   // plain read-write bit, software pulses it one then zero
   always_ff @(posedge clk) begin
      if (restore) begin
         apply_q <= `TOFGC_RST_ZERO;
      end else if (wr_update) begin
         apply_q <= reg_wdata[`TOFGC_BIT_APPLY]; // R02 R09
      end
   end

   // previous value, for the falling edge
   always_ff @(posedge clk) begin
      if (restore) begin
         apply_prev_q <= `TOFGC_RST_ZERO;
      end else begin
         apply_prev_q <= apply_q;
      end
   end

   // the pulse completes when the bit drops back to zero;
   // taking the new word at the rise would catch a half written setup
   assign apply_fall = apply_prev_q && !apply_q; // R02

   // ****************************************
   // synthesizer word in use
   // ****************************************

   // new frequency adopted only on the completed pulse
   always_ff @(posedge clk) begin
      if (restore) begin
         synth_active_q <= `TOFGC_RST_WORD;
      end else if (apply_fall) begin
         synth_active_q <= synth_setting; // R02
      end
   end

   // one cycle load strobe toward the synthesizer
   always_ff @(posedge clk) begin
      if (restore) begin
         synth_load_q <= `TOFGC_RST_ZERO;
      end else begin
         synth_load_q <= apply_fall; // R02
      end
   end

   // ****************************************
   // latency and ambient modes
   // ****************************************

   // early processing select
   always_ff @(posedge clk) begin
      if (restore) begin
         early_q <= `TOFGC_RST_ZERO;
      end else if (wr_latency) begin
         early_q <= reg_wdata[`TOFGC_BIT_EARLY]; // R03 R09
      end
   end

   // high ambient mode; legal only with shutter on, not checked here
   always_ff @(posedge clk) begin
      if (restore) begin
         ambient_q <= `TOFGC_RST_ZERO;
      end else if (wr_ambient) begin
         ambient_q <= reg_wdata[`TOFGC_BIT_AMBIENT]; // R04 R05 R09
      end
   end

   // ****************************************
   // power and setup
   // ****************************************

   // device wakes up in standby until software clears the bit
   always_ff @(posedge clk) begin
      if (restore) begin
         standby_q <= `TOFGC_RST_STANDBY; // R07
      end else if (wr_power) begin
         standby_q <= reg_wdata[`TOFGC_BIT_STANDBY]; // R06 R09
      end
   end

   // mandatory setup bit, zero until software sets it
   always_ff @(posedge clk) begin
      if (restore) begin
         setup_q <= `TOFGC_RST_ZERO; // R08
      end else if (wr_setup) begin
         setup_q <= reg_wdata[`TOFGC_BIT_SETUP]; // R08 R09
      end
   end

   // ****************************************
   // depth processing launch
   // ****************************************

   // early mode starts at the last quad, otherwise the start waits for
   // the next frame boundary; standby blocks a launch from idle but not one already waiting
   always_ff @(posedge clk) begin
      if (restore) begin
         state_q <= tofgc_pkg::TOFGC_IDLE;
         start_q <= `TOFGC_RST_ZERO;
      end else begin
         start_q <= `TOFGC_RST_ZERO;
         case (state_q)
            tofgc_pkg::TOFGC_IDLE: begin
               // readout finished while running
               if (quad_readout_done && !standby_q) begin // R06
                  if (early_q) begin
                     start_q <= 1'h1; // R03
                  end else begin
                     state_q <= tofgc_pkg::TOFGC_WAIT;
                  end
               end
            end
            tofgc_pkg::TOFGC_WAIT: begin
               // launch held for the boundary
               if (frame_boundary) begin
                  start_q <= 1'h1;
                  state_q <= tofgc_pkg::TOFGC_IDLE;
               end
            end
            default: begin
               state_q <= tofgc_pkg::TOFGC_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // read path
   // ****************************************

   // only documented fields appear; reserved and write-only bits
   // are rebuilt as zero rather than stored
   always_comb begin
      rd_word = `TOFGC_RST_WORD;
      case (reg_addr)
         `TOFGC_OFS_RESET: begin
            rd_word[`TOFGC_BIT_CLEAR] = clear_q; // R10
         end
         `TOFGC_OFS_UPDATE: begin
            rd_word[`TOFGC_BIT_APPLY] = apply_q; // R10
         end
         `TOFGC_OFS_LATENCY: begin
            rd_word[`TOFGC_BIT_EARLY] = early_q; // R09
         end
         `TOFGC_OFS_AMBIENT: begin
            rd_word[`TOFGC_BIT_AMBIENT] = ambient_q; // R09
         end
         `TOFGC_OFS_POWER: begin
            rd_word[`TOFGC_BIT_STANDBY] = standby_q; // R10
         end
         `TOFGC_OFS_SETUP: begin
            rd_word[`TOFGC_BIT_SETUP] = setup_q; // R10
         end
         default: begin
            // unmapped offsets read zero
            rd_word = `TOFGC_RST_WORD;
         end
      endcase
   end

   // data valid the cycle after the read strobe and only then
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= `TOFGC_RST_WORD;
      end else if (reg_rd) begin
         rdata_q <= rd_word;
      end else begin
         rdata_q <= `TOFGC_RST_WORD;
      end
   end

   // ****************************************
   // outputs
   // ****************************************

   assign reg_rdata = rdata_q;
   assign synth_active = synth_active_q;
   assign synth_load = synth_load_q;
   assign depth_start = start_q;
   // combinational so the hold covers the whole readout window
   assign pixel_reset_hold = ambient_q && readout_active; // R04
   assign standby = standby_q; // R06
   assign setup_done = setup_q;
   assign sensor_soft_clear = clear_q; // R01

   // ****************************************
   // checks
   // ****************************************

   default clocking tofgc_cb @(posedge clk);
   endclocking

   default disable iff (srst);

   // every field back to default right after a soft clear
   clear_restore_a: assert property ( // R01
      clear_q |=> standby_q && !early_q && !ambient_q && !setup_q
         && !apply_q && !clear_q && (state_q == tofgc_pkg::TOFGC_IDLE))
      else $error("soft clear did not restore defaults");

   // a clear write is seen for exactly one cycle
   soft_clear_a: assert property ( // R01
      (wr_reset && reg_wdata[`TOFGC_BIT_CLEAR] && !clear_q)
         |=> clear_q ##1 !clear_q)
      else $error("soft clear pulse has wrong length");

   // word in use changes only one cycle after the apply fall or a soft clear
   synth_adopt_a: assert property ( // R02
      (synth_active_q != $past(synth_active_q))
         |-> $past(apply_fall) || $past(clear_q))
      else $error("synth word changed without apply pulse");

   // early mode launches one cycle after the last quad
   early_start_a: assert property ( // R03
      (state_q == tofgc_pkg::TOFGC_IDLE && quad_readout_done
         && early_q && !standby_q && !clear_q) |=> depth_start)
      else $error("early start missing");

   // normal mode waits for the boundary
   late_wait_a: assert property ( // R03
      (state_q == tofgc_pkg::TOFGC_IDLE && quad_readout_done
         && !early_q && !standby_q && !clear_q)
         |=> !depth_start ##0 (state_q == tofgc_pkg::TOFGC_WAIT))
      else $error("normal mode started before frame boundary");

   // a stored ambient write must drive the hold if readout runs the next cycle,
   // checked from the write so a broken mode bit is caught too
   pixel_hold_a: assert property ( // R04
      (wr_ambient && reg_wdata[`TOFGC_BIT_AMBIENT] && !clear_q) ##1 readout_active
         |-> pixel_reset_hold)
      else $error("pixel reset not held during readout");

   // standby left only by a write clearing the bit
   standby_exit_a: assert property ( // R06
      (standby_q ##1 !standby_q) |-> $past(wr_power)
         && !$past(reg_wdata[`TOFGC_BIT_STANDBY]))
      else $error("standby left without software write");

   // power register reads only its standby bit
   reserved_read_a: assert property ( // R10
      (reg_rd && reg_addr == `TOFGC_OFS_POWER)
         |=> (reg_rdata[23:3] == 21'h0) && (reg_rdata[1:0] == 2'h0)
         && (reg_rdata[`TOFGC_BIT_STANDBY] == $past(standby_q)))
      else $error("reserved bits of power register not zero");

   // standby is one right after hard reset
   reset_default_a: assert property ( // R07
      disable iff (1'b0) srst |=> standby_q && !setup_q)
      else $error("wrong reset defaults");

endmodule

// *** testbench/tofgc_tb.sv ***
// self-checking bench for the time-of-flight global control bank
`timescale 1ns/1ns
`include "tofgc_map.svh"

// compare one observed value against its expectation and count it
`define CHK(nm, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); \
   end \
end

module tb;
   // ****************************************
   // stimulus and observation signals
   // ****************************************
   logic clk = 1'b0; // 100 MHz bench clock
   logic srst = 1'b1; // held for four cycles at start
   logic [7:0] reg_addr = 8'h00;
   logic [23:0] reg_wdata = 24'h000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [23:0] reg_rdata;
   logic [23:0] synth_setting = 24'h000000; // word offered to the synthesizer
   logic [23:0] synth_active;
   logic synth_load;
   logic quad_readout_done = 1'b0;
   logic frame_boundary = 1'b0;
   logic readout_active = 1'b0;
   logic depth_start;
   logic pixel_reset_hold;
   logic standby;
   logic setup_done;
   logic sensor_soft_clear;
   int failures = 0; // mismatches seen
   int check_count = 0; // comparisons made
   // offsets, reset words and all-ones read-back of the six registers
   logic [7:0] ofs [6] = '{`TOFGC_OFS_RESET, `TOFGC_OFS_UPDATE, `TOFGC_OFS_LATENCY,
      `TOFGC_OFS_AMBIENT, `TOFGC_OFS_POWER, `TOFGC_OFS_SETUP};
   logic [23:0] dflt [6] = '{24'h000000, 24'h000000, 24'h000000, 24'h000000,
      24'h000004, 24'h000000};
   logic [23:0] ones [6] = '{24'h000001, 24'h000004, 24'h400000, 24'h200000,
      24'h000004, 24'h002000};

   // free-running clock, 10 ns period
   always begin
      #5 clk = ~clk;
   end

   tofgc_regs dut_u (
      .clk(clk),
      .srst(srst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .synth_setting(synth_setting),
      .synth_active(synth_active),
      .synth_load(synth_load),
      .quad_readout_done(quad_readout_done),
      .frame_boundary(frame_boundary),
      .readout_active(readout_active),
      .depth_start(depth_start),
      .pixel_reset_hold(pixel_reset_hold),
      .standby(standby),
      .setup_done(setup_done),
      .sensor_soft_clear(sensor_soft_clear)
   );

   // ****************************************
   // bus and pulse helpers
   // ****************************************
   // one-cycle write, taken at the edge where the task returns
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // one-cycle read; data is sampled in the single cycle where it stands
   task automatic rd(input logic [7:0] a, output logic [23:0] q);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      q = reg_rdata;
   endtask

   // one-cycle pulse: 0 quad readout done, 1 frame boundary; ends settled
   task automatic pulse(input int which);
      @(posedge clk);
      if (which == 0) quad_readout_done <= 1'b1;
      else frame_boundary <= 1'b1;
      @(posedge clk);
      quad_readout_done <= 1'b0;
      frame_boundary <= 1'b0;
      #1;
   endtask

   // count depth starts now and over the next n cycles
   task automatic watch(input int n, output int c);
      c = (depth_start === 1'b1) ? 1 : 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (depth_start === 1'b1) c++;
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      logic [23:0] q;
      for (int i = 0; i < 6; i++) begin
         rd(ofs[i], q);
         `CHK("reset word", dflt[i], q)
      end
      `CHK("standby", 1'b1, standby)
      `CHK("setup", 1'b0, setup_done)
   endtask

   // all-ones writes: only the documented fields survive; unmapped ignored
   task automatic t_reserved();
      logic [23:0] q;
      for (int i = 1; i < 6; i++) begin
         wr(ofs[i], 24'hFFFFFF);
         rd(ofs[i], q);
         `CHK("masked word", ones[i], q)
      end
      `CHK("setup", 1'b1, setup_done)
      wr(8'h01, 24'hFFFFFF);
      rd(8'h01, q);
      `CHK("unmapped", 24'h000000, q)
      for (int i = 1; i < 6; i++) wr(ofs[i], 24'h000000);
      #1;
      `CHK("standby", 1'b0, standby)
   endtask

   // raising the apply bit alone adopts nothing; the fall does
   task automatic t_apply();
      int n;
      @(posedge clk);
      synth_setting <= 24'hA5C3E1;
      wr(`TOFGC_OFS_UPDATE, 24'h000004);
      repeat (4) @(posedge clk);
      #1;
      `CHK("synth idle", 24'h000000, synth_active)
      `CHK("load idle", 1'b0, synth_load)
      wr(`TOFGC_OFS_UPDATE, 24'h000000);
      n = 0;
      while (synth_load !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 6) begin
            failures++;
            wrap_up();
         end
      end
      `CHK("load delay", 1, n)
      `CHK("synth word", 24'hA5C3E1, synth_active)
      @(posedge clk);
      #1;
      `CHK("load end", 1'b0, synth_load)
   endtask

   // early select versus waiting for the frame boundary, and standby block
   task automatic t_launch();
      int c;
      wr(`TOFGC_OFS_LATENCY, 24'h400000);
      pulse(0);
      `CHK("early start", 1'b1, depth_start)
      wr(`TOFGC_OFS_LATENCY, 24'h000000);
      pulse(0);
      watch(3, c);
      `CHK("held start", 0, c)
      pulse(1);
      `CHK("boundary start", 1'b1, depth_start)
      wr(`TOFGC_OFS_POWER, 24'h000004);
      pulse(0);
      pulse(1);
      watch(3, c);
      `CHK("standby start", 0, c)
      wr(`TOFGC_OFS_POWER, 24'h000000);
   endtask

   // pixel reset follows readout only with high ambient set
   task automatic t_ambient();
      // the bench stands for a host that runs with the shutter enabled
      wr(`TOFGC_OFS_AMBIENT, 24'h200000);
      readout_active <= 1'b1;
      #1;
      `CHK("pixel hold", 1'b1, pixel_reset_hold)
      @(posedge clk);
      readout_active <= 1'b0;
      #1;
      `CHK("pixel idle", 1'b0, pixel_reset_hold)
      wr(`TOFGC_OFS_AMBIENT, 24'h000000);
      readout_active <= 1'b1;
      #1;
      `CHK("pixel off", 1'b0, pixel_reset_hold)
      @(posedge clk);
      readout_active <= 1'b0;
   endtask

   // soft clear restores every register after fields were changed
   task automatic t_clear();
      logic [23:0] q;
      wr(`TOFGC_OFS_LATENCY, 24'h400000);
      wr(`TOFGC_OFS_SETUP, 24'h002000);
      wr(`TOFGC_OFS_RESET, 24'h000001);
      #1;
      `CHK("clear pulse", 1'b1, sensor_soft_clear)
      @(posedge clk);
      #1;
      `CHK("clear end", 1'b0, sensor_soft_clear)
      `CHK("standby", 1'b1, standby)
      `CHK("synth word", 24'h000000, synth_active)
      for (int i = 0; i < 6; i++) begin
         rd(ofs[i], q);
         `CHK("cleared word", dflt[i], q)
      end
   endtask

   // ****************************************
   // verdict
   // ****************************************
   task automatic wrap_up();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // main sequence: reset, then each scenario in turn
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_reserved();
      t_apply();
      t_launch();
      t_ambient();
      t_clear();
      wrap_up();
   end
endmodule
